// File: shared/stsptr_map.svh
// Frame geometry, pointer field layout and reset values of the pointer block.
`ifndef STSPTR_MAP_SVH
`define STSPTR_MAP_SVH
`define STSPTR_LAST_COL  7'h59
`define STSPTR_LAST_ROW  4'h8
`define STSPTR_PTR_ROW   4'h3
`define STSPTR_H1_COL    7'h00
`define STSPTR_H2_COL    7'h01
`define STSPTR_H3_COL    7'h02
`define STSPTR_SPE_COL   7'h03
`define STSPTR_A1_BYTE   8'hF6
`define STSPTR_A2_BYTE   8'h28
`define STSPTR_PTR_MAX   10'h30E
`define STSPTR_I_MASK    10'h2AA
`define STSPTR_D_MASK    10'h155
`define STSPTR_H1_FLAGS  6'h18
`define STSPTR_DUMMY     8'h00
`define STSPTR_PTR_RST   10'h000
`endif

// File: shared/stsptr_pkg.sv
// Types shared by the pointer block.
package stsptr_pkg;
    typedef enum logic [1:0] {
        STSPTR_ADJ_NONE = 2'h0,
        STSPTR_ADJ_INC  = 2'h1,
        STSPTR_ADJ_DEC  = 2'h2
    } stsptr_adj_t;
    typedef enum logic {
        STSPTR_HUNT = 1'h0,
        STSPTR_SYNC = 1'h1
    } stsptr_sync_t;
    typedef struct packed {
        logic       aligned;
        logic       ptrValid;
        logic       ptrInvalid;
        logic       incSeen;
        logic       decSeen;
        logic [9:0] ptr;
    } stsptr_rx_t;
endpackage : stsptr_pkg

// File: src/stsptr_adjust.sv
// Pointer interpreter, slip buffer and pointer adjuster of the STS-1 stream.
`timescale 1ns/1ps
`include "stsptr_map.svh"
// =====================================================================
// Overview of operation
// RULE1: Pointer word is H1 high byte, H2 low byte; low ten bits locate J1.
// RULE2: Pointer zero puts J1 right after the H3 byte.
// RULE3: Ten-bit pointer above 782 is flagged invalid, not used.
// RULE4: Pointer is read only after frame alignment is found and kept.
// RULE5: Buffer writes on write clock edges, reads on read clock edges.
// RULE6: With fill inside the band no adjustment happens.
// RULE7: Low fill inserts a dummy byte to hold the fill level.
// RULE8: Dummy byte sits right after H3, delaying the payload one byte.
// RULE9: A positive stuff frame carries inverted increment bits.
// RULE10: Received dummy byte after an increment is discarded.
// RULE11: Frame after positive stuff has normal bits, pointer plus one. The code inverts the increment bits again if fill is still below LOW_MARK.
// RULE12: High fill carries a payload byte in the H3 slot.
// RULE13: Negative stuff inverts decrement bits; next frame pointer minus one.
// RULE14: Increment bits are odd pointer bits, decrement bits even bits.
module stsptr_adjust #(
    parameter int DEPTH     = 16,
    parameter int LOW_MARK  = 4,
    parameter int HIGH_MARK = 12
) (
    input  wire logic                sys_clk,
    input  wire logic                sys_rst,
    input  wire logic                slipWriteClock,
    input  wire logic [7:0]          slipInputData,
    input  wire logic                slipReadClock,
    output logic [7:0]               slipOutputData,
    output logic                     outStrobe,
    output logic                     posStuffEvt,
    output logic                     negStuffEvt,
    output stsptr_pkg::stsptr_rx_t   rxStatus
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] LOW_F  = LOW_MARK[AW:0];
    localparam logic [AW:0] HIGH_F = HIGH_MARK[AW:0];

    // =================================================================
    // Pin synchronisers and edge detection.
    logic [2:0] wrClkS_r;
    logic [2:0] rdClkS_r;
    logic [7:0] wrDataS1_r;
    logic [7:0] wrByte;
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            wrClkS_r   <= 3'h0;
            rdClkS_r   <= 3'h0;
            wrDataS1_r <= 8'h00;
            wrByte     <= 8'h00;
        end else begin
            wrClkS_r   <= {wrClkS_r[1:0], slipWriteClock};
            rdClkS_r   <= {rdClkS_r[1:0], slipReadClock};
            wrDataS1_r <= slipInputData;
            wrByte     <= wrDataS1_r;
        end
    end
    wire wrEdge = wrClkS_r[1] & ~wrClkS_r[2]; // RULE5
    wire rdEdge = rdClkS_r[1] & ~rdClkS_r[2]; // RULE5

    // =================================================================
    // Receive framing and pointer interpretation.
    stsptr_pkg::stsptr_sync_t rxSync_r;
    stsptr_pkg::stsptr_rx_t   rxStat_r;
    logic [3:0] rxRow_r;
    logic [6:0] rxCol_r;
    logic       prevA1_r;
    logic [7:0] h1Byte_r;
    wire rxLock = rxSync_r == stsptr_pkg::STSPTR_SYNC;
    wire rxEol  = rxCol_r == `STSPTR_LAST_COL;
    wire [6:0] rxColNxt = rxEol ? 7'h00 : rxCol_r + 7'h01;
    wire [3:0] rxRowNxt = !rxEol ? rxRow_r :
        (rxRow_r == `STSPTR_LAST_ROW) ? 4'h0 : rxRow_r + 4'h1;
    wire rxRow0 = rxRow_r == 4'h0;
    wire rxRowP = rxRow_r == `STSPTR_PTR_ROW;
    wire rxFrameErr = rxRow0 &&
        ((rxCol_r == 7'h00 && wrByte != `STSPTR_A1_BYTE) ||
         (rxCol_r == 7'h01 && wrByte != `STSPTR_A2_BYTE));
    wire rxAtH1 = rxLock && rxRowP && rxCol_r == `STSPTR_H1_COL;
    wire rxAtH2 = rxLock && rxRowP && rxCol_r == `STSPTR_H2_COL; // RULE4
    wire [15:0] ptrWord = {h1Byte_r, wrByte}; // RULE1
    wire [9:0]  rxNew   = ptrWord[9:0]; // RULE1
    wire [9:0]  rxDiff  = rxNew ^ rxStat_r.ptr;
    wire rxIsInc = rxStat_r.ptrValid && rxDiff == `STSPTR_I_MASK; // RULE14
    wire rxIsDec = rxStat_r.ptrValid && rxDiff == `STSPTR_D_MASK; // RULE14
    wire rxOver  = rxNew > `STSPTR_PTR_MAX; // RULE3
    wire [9:0] rxPlus  = (rxStat_r.ptr == `STSPTR_PTR_MAX) ? 10'h000 :
        rxStat_r.ptr + 10'h001;
    wire [9:0] rxMinus = (rxStat_r.ptr == 10'h000) ? `STSPTR_PTR_MAX :
        rxStat_r.ptr - 10'h001;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rxSync_r <= stsptr_pkg::STSPTR_HUNT;
            rxStat_r <= '0;
            rxRow_r  <= 4'h0;
            rxCol_r  <= 7'h00;
            prevA1_r <= 1'b0;
            h1Byte_r <= 8'h00;
        end else if (wrEdge) begin
            prevA1_r <= wrByte == `STSPTR_A1_BYTE;
            if (!rxLock) begin
                if (prevA1_r && wrByte == `STSPTR_A2_BYTE) begin // RULE4
                    rxSync_r         <= stsptr_pkg::STSPTR_SYNC;
                    rxStat_r.aligned <= 1'b1;
                    rxRow_r          <= 4'h0;
                    rxCol_r          <= `STSPTR_H3_COL;
                end
            end else begin
                rxRow_r <= rxRowNxt;
                rxCol_r <= rxColNxt;
                if (rxFrameErr) begin // RULE4
                    rxSync_r         <= stsptr_pkg::STSPTR_HUNT;
                    rxStat_r.aligned <= 1'b0;
                end
                if (rxAtH1) begin
                    h1Byte_r         <= wrByte;
                    rxStat_r.incSeen <= 1'b0;
                    rxStat_r.decSeen <= 1'b0;
                end
                if (rxAtH2) begin
                    if (rxIsInc) begin
                        rxStat_r.incSeen <= 1'b1;
                        rxStat_r.ptr     <= rxPlus;
                    end else if (rxIsDec) begin
                        rxStat_r.decSeen <= 1'b1;
                        rxStat_r.ptr     <= rxMinus;
                    end else if (rxOver) begin // RULE3
                        rxStat_r.ptrValid   <= 1'b0;
                        rxStat_r.ptrInvalid <= 1'b1;
                    end else begin
                        rxStat_r.ptr        <= rxNew;
                        rxStat_r.ptrValid   <= 1'b1;
                        rxStat_r.ptrInvalid <= 1'b0;
                    end
                end
            end
        end
    end
    assign rxStatus = rxStat_r;

    // =================================================================
    // Slip buffer.
    logic [7:0]  mem [DEPTH];
    logic [AW-1:0] wrIdx_r;
    logic [AW-1:0] rdIdx_r;
    logic [AW:0]   fill_r;
    wire bufEmpty = fill_r == '0;
    wire bufFull  = fill_r == DEPTH[AW:0];
    wire rxStuffSlot = rxRowP && rxCol_r == `STSPTR_SPE_COL &&
        rxStat_r.incSeen;
    wire rxH3Data = rxRowP && rxCol_r == `STSPTR_H3_COL && rxStat_r.decSeen;
    wire wrEn = wrEdge && rxLock && !bufFull &&
        ((rxCol_r >= `STSPTR_SPE_COL && !rxStuffSlot) || rxH3Data); // RULE10
    logic rdPop;
    always_ff @(posedge sys_clk) begin
        if (wrEn) begin
            mem[wrIdx_r] <= wrByte;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            wrIdx_r <= '0;
            rdIdx_r <= '0;
            fill_r  <= '0;
        end else begin
            wrIdx_r <= wrIdx_r + AW'(wrEn);
            rdIdx_r <= rdIdx_r + AW'(rdPop);
            fill_r  <= fill_r + (AW + 1)'(wrEn) - (AW + 1)'(rdPop);
        end
    end

    // =================================================================
    // Transmit frame generation and pointer adjustment.
    stsptr_pkg::stsptr_adj_t txAdj_r;
    stsptr_pkg::stsptr_adj_t txAdjNxt;
    logic [9:0] txPtr_r;
    logic [9:0] txPtrNxt;
    logic [3:0] txRow_r;
    logic [6:0] txCol_r;
    wire txEol = txCol_r == `STSPTR_LAST_COL;
    wire txRow0 = txRow_r == 4'h0;
    wire txRowP = txRow_r == `STSPTR_PTR_ROW;
    wire txStart = rdEdge && txRow0 && txCol_r == 7'h00;
    wire txInc = txAdj_r == stsptr_pkg::STSPTR_ADJ_INC;
    wire txDec = txAdj_r == stsptr_pkg::STSPTR_ADJ_DEC;
    wire txAtH3 = txRowP && txCol_r == `STSPTR_H3_COL;
    wire txAtStuff = txRowP && txCol_r == `STSPTR_SPE_COL && txInc; // RULE8
    wire [9:0] txWord = txPtr_r ^ (txInc ? `STSPTR_I_MASK : // RULE9
        txDec ? `STSPTR_D_MASK : 10'h000); // RULE13
    wire txHdr = (txRow0 || txRowP) && txCol_r < `STSPTR_H3_COL;
    wire [7:0] txHdrByte = txRow0 ?
        ((txCol_r == 7'h00) ? `STSPTR_A1_BYTE : `STSPTR_A2_BYTE) :
        ((txCol_r == `STSPTR_H1_COL) ? {`STSPTR_H1_FLAGS, txWord[9:8]} :
         txWord[7:0]); // RULE1
    assign rdPop = rdEdge && !bufEmpty && !txAtStuff && // RULE8
        (txCol_r >= `STSPTR_SPE_COL || (txAtH3 && txDec)); // RULE12
    wire [7:0] txSel = txHdr ? txHdrByte :
        rdPop ? mem[rdIdx_r] : `STSPTR_DUMMY;
    always_comb begin
        txAdjNxt = stsptr_pkg::STSPTR_ADJ_NONE; // RULE6
        if (fill_r < LOW_F) begin
            txAdjNxt = stsptr_pkg::STSPTR_ADJ_INC; // RULE7
        end else if (fill_r > HIGH_F) begin
            txAdjNxt = stsptr_pkg::STSPTR_ADJ_DEC; // RULE12
        end
        case (txAdj_r)
            stsptr_pkg::STSPTR_ADJ_INC: txPtrNxt = // RULE11
                (txPtr_r == `STSPTR_PTR_MAX) ? 10'h000 : txPtr_r + 10'h001;
            stsptr_pkg::STSPTR_ADJ_DEC: txPtrNxt = // RULE13
                (txPtr_r == 10'h000) ? `STSPTR_PTR_MAX : txPtr_r - 10'h001;
            default: txPtrNxt = txPtr_r;
        endcase
    end
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            txAdj_r        <= stsptr_pkg::STSPTR_ADJ_NONE;
            txPtr_r        <= `STSPTR_PTR_RST; // RULE2
            txRow_r        <= 4'h0;
            txCol_r        <= 7'h00;
            slipOutputData <= 8'h00;
            outStrobe      <= 1'b0;
            posStuffEvt    <= 1'b0;
            negStuffEvt    <= 1'b0;
        end else begin
            outStrobe   <= rdEdge;
            posStuffEvt <= rdEdge && txAtStuff;
            negStuffEvt <= rdEdge && txAtH3 && txDec;
            if (rdEdge) begin
                slipOutputData <= txSel;
                txCol_r <= txEol ? 7'h00 : txCol_r + 7'h01;
                if (txEol) begin
                    txRow_r <= (txRow_r == `STSPTR_LAST_ROW) ? 4'h0 :
                        txRow_r + 4'h1;
                end
            end
            if (txStart) begin
                txAdj_r <= txAdjNxt;
                txPtr_r <= txPtrNxt;
            end
        end
    end

    // =================================================================
    // Checks.
    a_ptr_invalid: assert property ( // RULE3
        @(posedge sys_clk) disable iff (sys_rst)
        (wrEdge && rxAtH2 && rxOver && !rxIsInc && !rxIsDec)
        |=> (rxStat_r.ptrInvalid && !rxStat_r.ptrValid))
        else $error("Out of range pointer not flagged.");
    a_hunt_holds_ptr: assert property ( // RULE4
        @(posedge sys_clk) disable iff (sys_rst)
        !rxLock |=> $stable(rxStat_r.ptr))
        else $error("Pointer changed without alignment.");
    a_rx_discard: assert property ( // RULE10
        @(posedge sys_clk) disable iff (sys_rst)
        (wrEdge && rxLock && rxStuffSlot) |-> !wrEn)
        else $error("Received stuff byte was stored.");
    a_read_on_edge: assert property ( // RULE5
        @(posedge sys_clk) disable iff (sys_rst)
        rdPop |-> (rdEdge && !bufEmpty))
        else $error("Buffer read off a read clock edge.");
    a_pos_dummy: assert property ( // RULE8
        @(posedge sys_clk) disable iff (sys_rst)
        posStuffEvt |-> (slipOutputData == `STSPTR_DUMMY && outStrobe))
        else $error("Stuff slot did not carry the dummy byte.");
    a_inc_bits: assert property ( // RULE9
        @(posedge sys_clk) disable iff (sys_rst)
        (rdEdge && txRowP && txCol_r == `STSPTR_H2_COL && txInc)
        |=> slipOutputData == ($past(txPtr_r[7:0]) ^ 8'hAA))
        else $error("Increment bits not inverted.");
    a_ptr_plus: assert property ( // RULE11
        @(posedge sys_clk) disable iff (sys_rst)
        (txStart && txInc) |=>
        (txPtr_r == $past(txPtr_r) + 10'h001 || txPtr_r == 10'h000))
        else $error("Pointer not stepped up after stuff.");
    a_ptr_minus: assert property ( // RULE13
        @(posedge sys_clk) disable iff (sys_rst)
        (txStart && txDec) |=>
        (txPtr_r == $past(txPtr_r) - 10'h001 || $past(txPtr_r) == 10'h000))
        else $error("Pointer not stepped down after stuff.");
    a_neg_h3: assert property ( // RULE12
        @(posedge sys_clk) disable iff (sys_rst)
        (rdEdge && txAtH3 && txDec && !bufEmpty) |-> rdPop ##1 negStuffEvt)
        else $error("H3 slot did not carry payload.");
    a_band_none: assert property ( // RULE6
        @(posedge sys_clk) disable iff (sys_rst)
        (txStart && fill_r >= LOW_F && fill_r <= HIGH_F)
        |=> txAdj_r == stsptr_pkg::STSPTR_ADJ_NONE)
        else $error("Adjustment with fill inside the band.");
endmodule : stsptr_adjust

// File: tb/stsptr_far_end.sv
// Far-end model that sends STS-1 frames byte by byte.
`timescale 1ns/1ps
// ==========================================================
// Far-end transmitter
module stsptr_far_end (
    input  wire logic  sys_clk,
    output logic       slipWriteClock,
    output logic [7:0] slipInputData
);
    initial begin
        slipWriteClock = 1'b0;
        slipInputData  = 8'h00;
    end

    // Sends one 9 x 90 frame; the byte clock stands still afterwards.
    task automatic send_frame(input logic [7:0] a1, input logic [15:0] word);
        logic [7:0] b;
        for (int i = 0; i < 810; i++) begin
            b = 8'(i) ^ 8'hA5;
            if (i == 0) b = a1;
            if (i == 1) b = 8'h28;
            if (i == 270) b = word[15:8];
            if (i == 271) b = word[7:0];
            @(negedge sys_clk) slipInputData = b;
            repeat (2) @(negedge sys_clk);
            slipWriteClock = 1'b1;
            repeat (2) @(negedge sys_clk);
            slipWriteClock = 1'b0;
        end
        @(negedge sys_clk) slipInputData = ~b;
    endtask : send_frame
endmodule : stsptr_far_end

// File: tb/tb_top.sv
// Self-checking bench of the pointer block.
`timescale 1ns/1ps
// ==========================================================
// Signals and instances
module tb_top;
    logic                   sys_clk;
    logic                   sys_rst;
    logic                   slipWriteClock;
    logic                   slipReadClock;
    logic [7:0]             slipInputData;
    logic [7:0]             slipOutputData;
    logic                   outStrobe;
    logic                   posStuffEvt;
    logic                   negStuffEvt;
    stsptr_pkg::stsptr_rx_t rxStatus;
    int                     fails = 0;
    int                     checks_done = 0;
    int                     cycles = 0;
    int                     outCount = 0;
    logic [7:0]             outData [1200];
    logic                   outPos [1200];
    logic                   outNeg [1200];
    localparam logic [36:0] ROWS [6] = '{
        {8'h00, 16'h6000, 3'b000, 10'h000},
        {8'hF6, 16'h6000, 3'b110, 10'h000},
        {8'hF6, 16'h630E, 3'b110, 10'h30E},
        {8'hF6, 16'h630F, 3'b101, 10'h000},
        {8'hF6, 16'h63FF, 3'b101, 10'h000},
        {8'hF6, 16'h6123, 3'b110, 10'h123}};

    stsptr_adjust #(.DEPTH(16), .LOW_MARK(4), .HIGH_MARK(12)) i_dut (
        .sys_clk(sys_clk), .sys_rst(sys_rst),
        .slipWriteClock(slipWriteClock), .slipInputData(slipInputData),
        .slipReadClock(slipReadClock), .slipOutputData(slipOutputData),
        .outStrobe(outStrobe), .posStuffEvt(posStuffEvt),
        .negStuffEvt(negStuffEvt), .rxStatus(rxStatus));
    stsptr_far_end i_far (.sys_clk(sys_clk),
        .slipWriteClock(slipWriteClock), .slipInputData(slipInputData));

    // ======================================================
    // Clock, capture and timeout
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (sys_rst) outCount <= 0;
        else if (outStrobe === 1'b1 && outCount < 1200) begin
            outData[outCount] <= slipOutputData;
            outPos[outCount]  <= posStuffEvt;
            outNeg[outCount]  <= negStuffEvt;
            outCount          <= outCount + 1;
        end
        if (cycles == 80000) begin
            fails = fails + 1;
            conclude();
        end
    end

    // ======================================================
    // Tasks
    task automatic check(input string what, input logic [15:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic do_reset();
        @(negedge sys_clk) sys_rst = 1'b1;
        repeat (3) @(negedge sys_clk);
        sys_rst = 1'b0;
        repeat (4) @(negedge sys_clk);
    endtask : do_reset

    task automatic read_bytes(input int n, input int low);
        repeat (n) begin
            @(negedge sys_clk) slipReadClock = 1'b1;
            repeat (2) @(negedge sys_clk);
            slipReadClock = 1'b0;
            repeat (low - 1) @(negedge sys_clk);
        end
        repeat (6) @(negedge sys_clk);
    endtask : read_bytes

    task automatic conclude();
        if (fails == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : conclude

    // ======================================================
    // Main sequence
    initial begin
        logic [36:0] r;
        sys_rst       = 1'b1;
        slipReadClock = 1'b0;
        do_reset();
        check("reset status", 16'(rxStatus), 16'h0000);
        check("reset out", {7'h0, outStrobe, slipOutputData}, 16'h0000);
        for (int k = 0; k < 6; k++) begin
            r = ROWS[k];
            do_reset();
            i_far.send_frame(r[36:29], r[28:13]);
            check("rx status", {3'h0, rxStatus.aligned, rxStatus.ptrValid,
                rxStatus.ptrInvalid, r[11] ? rxStatus.ptr : 10'h000},
                {3'h0, r[12:0]});
        end
        do_reset();
        i_far.send_frame(8'hF6, 16'h6100);
        i_far.send_frame(8'hF6, 16'h6100 ^ 16'h02AA);
        check("inc seen", 16'(rxStatus.incSeen), 16'h0001);
        i_far.send_frame(8'hF6, 16'h6101);
        check("ptr after inc", {6'h0, rxStatus.ptr}, 16'h0101);
        i_far.send_frame(8'hF6, 16'h6101 ^ 16'h0155);
        check("dec seen", 16'(rxStatus.decSeen), 16'h0001);
        i_far.send_frame(8'hF6, 16'h6100);
        check("ptr after dec", {6'h0, rxStatus.ptr}, 16'h0100);
        do_reset();
        // Reader runs at the writer's rate, one cycle ahead of the byte
        // that the writer sends sixteen bytes later, so the fill stays
        // between 12 and 16 and the H3 slot pops byte 273 of the frame.
        fork
            i_far.send_frame(8'hF6, 16'h6000);
            begin
                repeat (81) @(negedge sys_clk);
                read_bytes(280, 3);
            end
        join
        check("tx A1 A2", {outData[0], outData[1]}, 16'hF628);
        check("tx payload", {8'h00, outData[3]}, 16'h00A6);
        check("tx dec word", {outData[270], outData[271]}, 16'h6155);
        check("tx H3", {7'h0, outNeg[272], outData[272]}, 16'h01B4);
        do_reset();
        read_bytes(1100, 2);
        check("tx inc word", {outData[270], outData[271]}, 16'h62AA);
        check("stuff", {7'h0, outPos[273], outData[273]}, 16'h0100);
        check("tx no neg", {15'h0, outNeg[272]}, 16'h0000);
        check("tx word 2", {outData[1080], outData[1081]}, 16'h62AB);
        conclude();
    end
endmodule : tb_top
